/* dv/wtk_tb.sv */
// Self-checking bench for the 32 kHz watchdog timer top.
// Assumes the logic/ files are compiled first and wtk_consts.svh is on the include path.
`timescale 1ns/1ps
`include "wtk_consts.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end

module tb;
	import wtk_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_system_reset = 1'b0;
	logic i_clk32k = 1'b0;
	logic i_host_sel = 1'b0;
	logic i_host_wr = 1'b0;
	logic [7:0] i_host_addr = 8'h00;
	logic [31:0] i_host_wdata = 32'h0;
	logic [2:0] stall_src = 3'h0;
	logic [31:0] o_host_rdata;
	logic o_host_ack, o_expiry_interrupt, o_ec_reset, o_watchdog_indication, o_low_power;
	int n_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int q_ecr[$];
	int m_reload, m_ctl, m_ien, m_flag, r, ex;
	logic [31:0] q, c1, c2, c3;

	always #5 i_mclk = ~i_mclk;
	always #20 i_clk32k = ~i_clk32k;

	wtk_top u_wtk_top (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_system_reset(i_system_reset),
		.i_clk32k(i_clk32k), .i_host_sel(i_host_sel), .i_host_wr(i_host_wr),
		.i_host_addr(i_host_addr), .i_host_wdata(i_host_wdata), .o_host_rdata(o_host_rdata),
		.o_host_ack(o_host_ack), .i_debug_active(stall_src[2]),
		.i_week_timer_active(stall_src[1]), .i_hibernation_active(stall_src[0]),
		.o_expiry_interrupt(o_expiry_interrupt), .o_ec_reset(o_ec_reset),
		.o_watchdog_indication(o_watchdog_indication), .o_low_power(o_low_power));

	// Cycle stamps of every controller reset pulse
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (o_ec_reset === 1'b1) begin
			q_ecr.push_back(cyc);
		end
	end

	task automatic report_and_stop();
		$display("tests %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_host_sel <= 1'b1;
		i_host_wr <= wr;
		i_host_addr <= a;
		i_host_wdata <= d;
		@(posedge i_mclk);
		i_host_sel <= 1'b0;
		#1;
		`CHK(o_host_ack, 1'b1)
		q = o_host_rdata;
	endtask

	// Write, keeping the register model in step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
		case (a)
			`WTK_OFF_RELOAD: m_reload = d[15:0];
			`WTK_OFF_CONTROL: m_ctl = d & 32'h21d;
			`WTK_OFF_STATUS: m_flag = d[0] ? 0 : m_flag;
			`WTK_OFF_INT_EN: m_ien = d[0];
			default: ;
		endcase
	endtask

	function automatic logic [31:0] exp_rd(input logic [7:0] a);
		case (a)
			`WTK_OFF_RELOAD: return m_reload;
			`WTK_OFF_CONTROL: return m_ctl;
			`WTK_OFF_COUNT: return 32'h0000ffff;
			`WTK_OFF_STATUS: return m_flag;
			`WTK_OFF_INT_EN: return m_ien;
			default: return 32'h0;
		endcase
	endfunction

	// All registers against the model, count at its default, plus an unmapped place
	task automatic chk_all();
		logic [7:0] a;
		for (int i = 0; i < 7; i++) begin
			a = 8'(i * 4);
			acc(1'b0, a, 32'h0);
			`CHK(q, exp_rd(a))
		end
	endtask

	task automatic sys_reset();
		@(posedge i_mclk);
		i_system_reset <= 1'b1;
		@(posedge i_mclk);
		i_system_reset <= 1'b0;
		m_reload = 32'hffff;
		m_ctl = 0;
		m_ien = 0;
		#1;
		`CHK(o_watchdog_indication, 1'b0)
	endtask

	task automatic wait_ind();
		for (int i = 0; i < 3000 && o_watchdog_indication !== 1'b1; i++) begin
			@(posedge i_mclk);
		end
		`CHK(o_watchdog_indication, 1'b1)
	endtask

	initial begin
		#400000;
		n_errors++;
		report_and_stop();
	end

	initial begin
		void'($urandom(31));
		m_reload = 32'hffff;
		m_ctl = 0;
		m_ien = 0;
		m_flag = 0;
		repeat (3) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		wr(8'h18, $urandom);
		chk_all();
		`CHK(o_low_power, 1'b1)
		$display("test reset_values done");

		r = 1 + $urandom % 3;
		wr(`WTK_OFF_INT_EN, 32'h1);
		wr(`WTK_OFF_RELOAD, r);
		wr(`WTK_OFF_CONTROL, 32'h201);
		wait_ind();
		m_ctl = m_ctl & 32'h1d;
		m_flag = 1;
		`CHK(o_expiry_interrupt, 1'b1)
		`CHK(q_ecr.size(), 0)
		acc(1'b0, `WTK_OFF_COUNT, 32'h0);
		`CHK(q, 32'(r))
		acc(1'b0, `WTK_OFF_CONTROL, 32'h0);
		`CHK(q, exp_rd(`WTK_OFF_CONTROL))
		sys_reset();
		chk_all();
		`CHK(o_expiry_interrupt, 1'b0)
		wr(`WTK_OFF_STATUS, 32'h1);
		chk_all();
		$display("test interrupt_expiry done");

		r = 1 + $urandom % 3;
		q_ecr.delete();
		wr(`WTK_OFF_RELOAD, r);
		wr(`WTK_OFF_CONTROL, 32'h1);
		for (int i = 0; i < 3000 && q_ecr.size() < 2; i++) begin
			@(posedge i_mclk);
		end
		`CHK(q_ecr.size(), 2)
		ex = (r + 1) * 33 * 4;
		`CHK((q_ecr[1] - q_ecr[0] >= ex - 4) && (q_ecr[1] - q_ecr[0] <= ex + 4), 1'b1)
		`CHK(o_watchdog_indication, 1'b1)
		wr(`WTK_OFF_CONTROL, 32'h0);
		sys_reset();
		chk_all();
		$display("test reset_expiry done");

		wr(`WTK_OFF_RELOAD, 32'h40);
		wr(`WTK_OFF_CONTROL, 32'h1d);
		repeat (300) @(posedge i_mclk);
		for (int s = 0; s < 3; s++) begin
			// Only source s is enabled; the other two must not stall
			wr(`WTK_OFF_CONTROL, 32'h1 | (32'h4 << s));
			@(posedge i_mclk);
			stall_src <= 3'h7 ^ 3'(1 << s);
			repeat (3) @(posedge i_mclk);
			#1;
			`CHK(o_low_power, 1'b0)
			@(posedge i_mclk);
			stall_src <= 3'(1 << s);
			repeat (10) @(posedge i_mclk);
			acc(1'b0, `WTK_OFF_COUNT, 32'h0);
			c1 = q;
			repeat (300) @(posedge i_mclk);
			acc(1'b0, `WTK_OFF_COUNT, 32'h0);
			`CHK(q, c1)
			`CHK(o_low_power, 1'b1)
			@(posedge i_mclk);
			stall_src <= 3'h0;
			repeat (300) @(posedge i_mclk);
			acc(1'b0, `WTK_OFF_COUNT, 32'h0);
			c3 = c1 - q;
			`CHK((c3 >= 1) && (c3 <= 3), 1'b1)
			`CHK(o_low_power, 1'b0)
		end
		// Serviced well inside the interval, so no expiry occurs
		wr(`WTK_OFF_SERVICE, $urandom);
		acc(1'b0, `WTK_OFF_COUNT, 32'h0);
		`CHK(q, 32'h40)
		wr(`WTK_OFF_CONTROL, 32'h0);
		repeat (3) @(posedge i_mclk);
		`CHK(o_low_power, 1'b1)
		acc(1'b0, `WTK_OFF_COUNT, 32'h0);
		c2 = q;
		wr(`WTK_OFF_SERVICE, $urandom);
		repeat (300) @(posedge i_mclk);
		acc(1'b0, `WTK_OFF_COUNT, 32'h0);
		`CHK(q, c2)
		wr(`WTK_OFF_RELOAD, 32'h123);
		acc(1'b0, `WTK_OFF_COUNT, 32'h0);
		`CHK(q, 32'h123)
		$display("test stall_service done");
		report_and_stop();
	end
endmodule // tb

/* logic/wtk_consts.svh */
// Constants of the 32 kHz watchdog timer: offsets, field positions, reset values, counts.
// Assumes inclusion by bare name from the package and from the design modules.
`ifndef WTK_CONSTS_SVH
`define WTK_CONSTS_SVH

`define WTK_ADDR_W 8
`define WTK_OFF_RELOAD 8'h00
`define WTK_OFF_CONTROL 8'h04
`define WTK_OFF_SERVICE 8'h08
`define WTK_OFF_COUNT 8'h0c
`define WTK_OFF_STATUS 8'h10
`define WTK_OFF_INT_EN 8'h14

`define WTK_CTL_RUN_BIT 0
`define WTK_CTL_HIB_STALL_BIT 2
`define WTK_CTL_WEEK_STALL_BIT 3
`define WTK_CTL_DBG_STALL_BIT 4
`define WTK_CTL_ACTION_BIT 9
`define WTK_STS_EVENT_BIT 0
`define WTK_IEN_BIT 0

`define WTK_RELOAD_RST 16'hffff
`define WTK_COUNT_RST 16'hffff
`define WTK_COUNT_ZERO 16'h0000

// 32 kHz periods per count step, and the width of the prescaler
`define WTK_TICKS_PER_COUNT 6'h21
`define WTK_PRESCALE_W 6

`endif

/* logic/wtk_div.sv */
// Prescaler: one decrement pulse per set number of 32 kHz ticks while running.
// Assumes restart is a same-clock pulse from the core.
`timescale 1ns/1ps
`include "wtk_consts.svh"

module wtk_div
	import wtk_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Tick and control
	wtk_tick_if.div tk
);

	wtk_div_state_type s_q;
	wtk_div_state_type s_d;

	always_comb begin
		s_d = s_q;
		s_d.dec = 1'b0;
		if (tk.restart) begin
			s_d.cnt = '0;
		end else if (tk.run && tk.tick32) begin
			// Frozen while not running so a stall resumes mid-step
			if (s_q.cnt == `WTK_TICKS_PER_COUNT - 6'h1) begin
				s_d.cnt = '0;
				s_d.dec = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + 6'h1;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tk.dec = s_q.dec;

	AST_DIV_WRAP: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		s_q.dec |-> s_q.cnt == '0) else $error("decrement without prescaler wrap");
	AST_DIV_FREEZE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		(!tk.run && !tk.restart) |=> $stable(s_q.cnt)) else $error("prescaler moved while held");

endmodule // wtk_div

/* logic/wtk_pkg.sv */
// Types shared by the watchdog timer modules.
// Assumes wtk_consts.svh is on the include path.
`include "wtk_consts.svh"

package wtk_pkg;

	typedef enum logic [2:0] {
		WTK_OFF = 3'h1,
		WTK_RUN = 3'h2,
		WTK_HOLD = 3'h4
	} wtk_mode_type;

	typedef struct packed {
		logic [15:0] reload;
		logic run_enable;
		logic expiry_action_select;
		logic [2:0] stall_en;
		logic [15:0] count;
		logic expiry_event_flag;
		logic int_enable;
		wtk_mode_type mode;
		logic [31:0] rdata;
		logic ack;
		logic ec_reset;
		logic indication;
		logic expiry_interrupt;
		logic low_power;
	} wtk_top_state_type;

	typedef struct packed {
		logic [2:0] sync;
		logic level;
		logic tick;
	} wtk_sync_state_type;

	typedef struct packed {
		logic [`WTK_PRESCALE_W-1:0] cnt;
		logic dec;
	} wtk_div_state_type;

endpackage

/* logic/wtk_sync.sv */
// Brings the 32 kHz clock into the i_mclk domain and emits one pulse per rising edge.
// Assumes i_clk32k is asynchronous to i_mclk and far slower.
`timescale 1ns/1ps

module wtk_sync
	import wtk_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Slow clock pin
	input wire logic i_clk32k,
	// Tick out
	wtk_tick_if.sync tk
);

	wtk_sync_state_type s_q;
	wtk_sync_state_type s_d;

	always_comb begin
		s_d = s_q;
		s_d.sync = {s_q.sync[1:0], i_clk32k};
		s_d.tick = 1'b0;
		// A level counts only once stages two and three agree
		if (s_q.sync[1] == s_q.sync[2]) begin
			s_d.level = s_q.sync[2];
			s_d.tick = s_q.sync[2] & ~s_q.level;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tk.tick32 = s_q.tick;

	AST_TICK_SINGLE: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
		s_q.tick |=> !s_q.tick) else $error("slow clock tick lasted two cycles");

endmodule // wtk_sync

/* logic/wtk_tick_if.sv */
// Carrier between the watchdog core and its 32 kHz tick and prescaler helpers.
// Assumes all three modules share i_mclk.
`timescale 1ns/1ps

interface wtk_tick_if;
	logic tick32;
	logic run;
	logic restart;
	logic dec;

	modport sync (output tick32);
	modport div (input tick32, input run, input restart, output dec);
	modport core (output run, output restart, input dec);
endinterface

/* logic/wtk_top.sv */
// Watchdog timer core: host registers, countdown, stall, expiry actions.
// Assumes a registered host port on i_mclk, stall sources and system reset from same-clock logic.
`timescale 1ns/1ps
`include "wtk_consts.svh"

//
// Operation
// - Countdown timing is paced by the 32 kHz clock, never by host clock.
// - Host reads and writes finish in one host cycle, no slow-clock wait.
// - Software loads the count, then sets run enable; counting then starts.
// - Clearing run enable stops counting and enters low power with clocks gated.
// - Underflow raises an expiry event and sets the reset-status indication.
// - Counter reloads on reload write, service write or expiry event.
// - Interval runs from loaded count down to zero; event on underflow past zero.
// - Count drops by one every 33 periods of the 32 kHz clock.
// - Three stall enables; an enabled active source holds count, enters low power.
// - After a stall, counting resumes from the held value without reload.
// - Expiry pulse raises interrupt if control bit 9 is 1, else resets controller.
// - Expiry indication stays until the next system reset.
// - System reset returns all registers except the status flag to defaults.
// - Bits surviving an expiry are reset only by the keep-watchdog reset.
// - Any service write reloads and restarts counting while enabled; reads give zero.
// - Status bit 0 is the interrupt flag, write-1 clears, survives expiry.
// - Control bits 4, 3, 2 stall on debug, week timer, hibernation timer.
module wtk_top
	import wtk_pkg::*;
(
	// Clock and keep-watchdog reset (power-on only)
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// System reset, synchronous, asserted after power-on and after expiry
	input wire logic i_system_reset,
	// Slow clock pin
	input wire logic i_clk32k,
	// Host register port
	input wire logic i_host_sel,
	input wire logic i_host_wr,
	input wire logic [`WTK_ADDR_W-1:0] i_host_addr,
	input wire logic [31:0] i_host_wdata,
	output logic [31:0] o_host_rdata,
	output logic o_host_ack,
	// Stall sources
	input wire logic i_debug_active,
	input wire logic i_week_timer_active,
	input wire logic i_hibernation_active,
	// Expiry and low power outputs
	output logic o_expiry_interrupt,
	output logic o_ec_reset,
	output logic o_watchdog_indication,
	output logic o_low_power
);

	wtk_top_state_type s_q;
	wtk_top_state_type s_d;
	wtk_tick_if tk ();

	logic wr_reload;
	logic wr_control;
	logic wr_service;
	logic wr_status;
	logic wr_int_en;
	logic rd;
	logic kick;
	logic stall;
	logic expire;
	logic reload_now;
	logic [31:0] rd_mux;

	wtk_sync u_sync (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_clk32k(i_clk32k),
		.tk(tk.sync)
	);

	wtk_div u_div (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.tk(tk.div)
	);

	// Host decode; every selected access completes the next cycle
	always_comb begin
		wr_reload = i_host_sel && i_host_wr && i_host_addr == `WTK_OFF_RELOAD;
		wr_control = i_host_sel && i_host_wr && i_host_addr == `WTK_OFF_CONTROL;
		wr_service = i_host_sel && i_host_wr && i_host_addr == `WTK_OFF_SERVICE;
		wr_status = i_host_sel && i_host_wr && i_host_addr == `WTK_OFF_STATUS;
		wr_int_en = i_host_sel && i_host_wr && i_host_addr == `WTK_OFF_INT_EN;
		rd = i_host_sel && !i_host_wr;
	end

	// Stall sources gated by their enables
	always_comb begin
		stall = (s_q.stall_en[2] && i_debug_active)
			|| (s_q.stall_en[1] && i_week_timer_active)
			|| (s_q.stall_en[0] && i_hibernation_active);
	end

	always_comb begin
		kick = wr_service && s_q.run_enable;
		// Underflow past zero, only when a step is due in run mode
		expire = tk.dec && s_q.mode == WTK_RUN && s_q.count == `WTK_COUNT_ZERO;
		reload_now = wr_reload || kick || expire;
	end

	// Read data mux; unmapped and service offsets read zero
	always_comb begin
		rd_mux = 32'h0;
		case (i_host_addr)
			`WTK_OFF_RELOAD: rd_mux = {16'h0, s_q.reload};
			`WTK_OFF_CONTROL: begin
				rd_mux[`WTK_CTL_ACTION_BIT] = s_q.expiry_action_select;
				rd_mux[`WTK_CTL_DBG_STALL_BIT] = s_q.stall_en[2];
				rd_mux[`WTK_CTL_WEEK_STALL_BIT] = s_q.stall_en[1];
				rd_mux[`WTK_CTL_HIB_STALL_BIT] = s_q.stall_en[0];
				rd_mux[`WTK_CTL_RUN_BIT] = s_q.run_enable;
			end
			`WTK_OFF_SERVICE: rd_mux = 32'h0;
			`WTK_OFF_COUNT: rd_mux = {16'h0, s_q.count};
			`WTK_OFF_STATUS: rd_mux[`WTK_STS_EVENT_BIT] = s_q.expiry_event_flag;
			`WTK_OFF_INT_EN: rd_mux[`WTK_IEN_BIT] = s_q.int_enable;
			default: rd_mux = 32'h0;
		endcase
	end

	always_comb begin
		s_d = s_q;
		s_d.ack = i_host_sel;
		s_d.rdata = rd ? rd_mux : 32'h0;
		s_d.ec_reset = 1'b0;

		// Register writes
		if (wr_reload) begin
			s_d.reload = i_host_wdata[15:0];
		end
		if (wr_control) begin
			s_d.run_enable = i_host_wdata[`WTK_CTL_RUN_BIT];
			s_d.expiry_action_select = i_host_wdata[`WTK_CTL_ACTION_BIT];
			s_d.stall_en = {i_host_wdata[`WTK_CTL_DBG_STALL_BIT],
				i_host_wdata[`WTK_CTL_WEEK_STALL_BIT],
				i_host_wdata[`WTK_CTL_HIB_STALL_BIT]};
		end
		if (wr_int_en) begin
			s_d.int_enable = i_host_wdata[`WTK_IEN_BIT];
		end
		if (wr_status && i_host_wdata[`WTK_STS_EVENT_BIT]) begin
			s_d.expiry_event_flag = 1'b0;
		end

		// Mode: off, running, or held by a stall
		case (s_q.mode)
			WTK_OFF: begin
				if (s_q.run_enable) begin
					s_d.mode = stall ? WTK_HOLD : WTK_RUN;
				end
			end
			WTK_RUN: begin
				if (!s_q.run_enable) begin
					s_d.mode = WTK_OFF;
				end else if (stall) begin
					s_d.mode = WTK_HOLD;
				end
			end
			WTK_HOLD: begin
				if (!s_q.run_enable) begin
					s_d.mode = WTK_OFF;
				end else if (!stall) begin
					s_d.mode = WTK_RUN;
				end
			end
			default: s_d.mode = WTK_OFF;
		endcase

		// Counter: reload wins over a step; held value kept across stalls
		if (wr_reload) begin
			s_d.count = i_host_wdata[15:0];
		end else if (reload_now) begin
			s_d.count = s_q.reload;
		end else if (tk.dec && s_q.mode == WTK_RUN) begin
			s_d.count = s_q.count - 16'h1;
		end

		// Expiry: interrupt path clears its select bit, else controller reset
		if (expire) begin
			s_d.indication = 1'b1;
			if (s_q.expiry_action_select) begin
				s_d.expiry_event_flag = 1'b1;
				s_d.expiry_action_select = 1'b0;
			end else begin
				s_d.ec_reset = 1'b1;
			end
		end

		s_d.expiry_interrupt = s_d.expiry_event_flag && s_d.int_enable;
		s_d.low_power = s_d.mode != WTK_RUN;

		// System reset returns all but the expiry flag to defaults
		if (i_system_reset) begin
			s_d = '0;
			s_d.reload = `WTK_RELOAD_RST;
			s_d.count = `WTK_COUNT_RST;
			s_d.mode = WTK_OFF;
			s_d.low_power = 1'b1;
			s_d.ack = i_host_sel;
			s_d.expiry_event_flag = s_q.expiry_event_flag;
			s_d.expiry_interrupt = 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s_q <= '{reload: `WTK_RELOAD_RST, count: `WTK_COUNT_RST, mode: WTK_OFF,
				low_power: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// Prescaler runs only in run mode and restarts with every reload
	assign tk.run = s_q.mode == WTK_RUN;
	assign tk.restart = reload_now || i_system_reset;

	assign o_host_rdata = s_q.rdata;
	assign o_host_ack = s_q.ack;
	assign o_expiry_interrupt = s_q.expiry_interrupt;
	assign o_ec_reset = s_q.ec_reset;
	assign o_watchdog_indication = s_q.indication;
	assign o_low_power = s_q.low_power;

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	sequence seq_underflow;
		tk.dec && s_q.mode == WTK_RUN && s_q.count == `WTK_COUNT_ZERO && !i_system_reset;
	endsequence

	sequence seq_kick_live;
		wr_service && s_q.run_enable && !wr_reload && !i_system_reset;
	endsequence

	AST_ACK_NEXT: assert property (i_host_sel |=> o_host_ack)
		else $error("host access not answered next cycle");
	AST_RELOAD_WRITE: assert property (wr_reload && !i_system_reset
		|=> s_q.count == $past(i_host_wdata[15:0])) else $error("reload write missed");
	AST_SERVICE_RELOAD: assert property (seq_kick_live |=> s_q.count == $past(s_q.reload))
		else $error("service write did not reload");
	AST_SERVICE_IGNORED: assert property (wr_service && !s_q.run_enable && !wr_reload
		&& !tk.dec && !i_system_reset |=> $stable(s_q.count)) else $error("service acted while off");
	AST_HOLD_STABLE: assert property (s_q.mode == WTK_HOLD && !reload_now && !i_system_reset
		|=> $stable(s_q.count)) else $error("count moved during stall");
	AST_OFF_STABLE: assert property (s_q.mode == WTK_OFF && !reload_now && !i_system_reset
		|-> o_low_power ##1 $stable(s_q.count)) else $error("count moved while disabled");
	AST_EXPIRE_IRQ: assert property (seq_underflow ##0 s_q.expiry_action_select
		|=> s_q.expiry_event_flag && !s_q.expiry_action_select && !o_ec_reset
		##0 s_q.count == $past(s_q.reload)) else $error("interrupt expiry path wrong");
	AST_EXPIRE_RESET: assert property (seq_underflow ##0 !s_q.expiry_action_select
		|=> o_ec_reset ##1 !o_ec_reset) else $error("reset expiry pulse wrong");
	AST_INDICATION: assert property (seq_underflow |=> o_watchdog_indication
		##1 (o_watchdog_indication || $past(i_system_reset))) else $error("indication lost");
	AST_FLAG_STICKY: assert property (s_q.expiry_event_flag
		&& !(wr_status && i_host_wdata[`WTK_STS_EVENT_BIT]) |=> s_q.expiry_event_flag)
		else $error("status flag dropped without clear");
	AST_STEP_ONLY_ON_DEC: assert property (!tk.dec && !reload_now && !i_system_reset
		|=> $stable(s_q.count)) else $error("count changed without step");
	AST_SYS_RESET: assert property (i_system_reset |=> s_q.count == `WTK_COUNT_RST
		&& !s_q.run_enable && s_q.mode == WTK_OFF) else $error("system reset incomplete");

	sequence seq_host_read;
		rd && !i_system_reset;
	endsequence

	// Host port answers
	AST_ACK_ONLY_SEL: assert property (!i_host_sel
		|=> !o_host_ack)
		else $error("acknowledge without access");
	AST_RDATA_IDLE: assert property (!rd
		|=> o_host_rdata == 32'h0)
		else $error("read data without read");
	AST_READ_SERVICE: assert property (seq_host_read
		##0 i_host_addr == `WTK_OFF_SERVICE |=> o_host_rdata == 32'h0)
		else $error("service register read not zero");
	AST_READ_COUNT: assert property (seq_host_read
		##0 i_host_addr == `WTK_OFF_COUNT |=> o_host_rdata == {16'h0, $past(s_q.count)})
		else $error("count read wrong");
	AST_READ_RELOAD: assert property (seq_host_read
		##0 i_host_addr == `WTK_OFF_RELOAD |=> o_host_rdata == {16'h0, $past(s_q.reload)})
		else $error("reload read wrong");
	AST_READ_STATUS: assert property (seq_host_read
		##0 i_host_addr == `WTK_OFF_STATUS
		|=> o_host_rdata == {31'h0, $past(s_q.expiry_event_flag)}) else $error("status read wrong");
	AST_READ_UNMAPPED: assert property (seq_host_read
		##0 i_host_addr > `WTK_OFF_INT_EN |=> o_host_rdata == 32'h0)
		else $error("unmapped read not zero");

	// Register writes
	AST_RELOAD_REG: assert property (wr_reload && !i_system_reset
		|=> s_q.reload == $past(i_host_wdata[15:0]))
		else $error("reload register not written");
	AST_RUN_WRITE: assert property (wr_control && !i_system_reset
		|=> s_q.run_enable == $past(i_host_wdata[`WTK_CTL_RUN_BIT]))
		else $error("run enable not written");
	AST_DBG_STALL_WRITE: assert property (wr_control && !i_system_reset
		|=> s_q.stall_en[2] == $past(i_host_wdata[`WTK_CTL_DBG_STALL_BIT]))
		else $error("debug stall enable not written");
	AST_WEEK_STALL_WRITE: assert property (wr_control && !i_system_reset
		|=> s_q.stall_en[1] == $past(i_host_wdata[`WTK_CTL_WEEK_STALL_BIT]))
		else $error("week timer stall enable not written");
	AST_HIB_STALL_WRITE: assert property (wr_control && !i_system_reset
		|=> s_q.stall_en[0] == $past(i_host_wdata[`WTK_CTL_HIB_STALL_BIT]))
		else $error("hibernation stall enable not written");
	AST_ACTION_WRITE: assert property (wr_control && !expire && !i_system_reset
		|=> s_q.expiry_action_select == $past(i_host_wdata[`WTK_CTL_ACTION_BIT]))
		else $error("expiry action select not written");
	AST_FLAG_W1C: assert property (wr_status && i_host_wdata[`WTK_STS_EVENT_BIT]
		&& !expire && !i_system_reset |=> !s_q.expiry_event_flag)
		else $error("status flag not cleared by write one");
	AST_FLAG_SYS_RESET: assert property (i_system_reset
		|=> s_q.expiry_event_flag == $past(s_q.expiry_event_flag))
		else $error("status flag lost in system reset");

	// Mode and low power
	AST_ACTIVATE: assert property (s_q.mode == WTK_OFF && s_q.run_enable
		&& !stall && !i_system_reset |=> s_q.mode == WTK_RUN)
		else $error("enable did not start counting");
	AST_DEACTIVATE: assert property (s_q.mode != WTK_OFF && !s_q.run_enable
		&& !i_system_reset |=> s_q.mode == WTK_OFF)
		else $error("disable did not stop counting");
	AST_STALL_ENTER: assert property (s_q.mode == WTK_RUN && s_q.run_enable
		&& stall && !i_system_reset |=> s_q.mode == WTK_HOLD)
		else $error("stall not entered");
	AST_STALL_LEAVE: assert property (s_q.mode == WTK_HOLD && s_q.run_enable
		&& !stall && !i_system_reset |=> s_q.mode == WTK_RUN)
		else $error("stall not left");
	AST_STALL_DISABLED: assert property (s_q.mode == WTK_RUN && s_q.run_enable
		&& s_q.stall_en == 3'h0 && !i_system_reset |=> s_q.mode == WTK_RUN)
		else $error("stall without enabled source");
	AST_LOW_POWER_MODE: assert property (o_low_power
		== (s_q.mode != WTK_RUN))
		else $error("low power does not follow mode");

	// Counting and expiry
	AST_STEP_BY_ONE: assert property (tk.dec && s_q.mode == WTK_RUN && !reload_now
		&& s_q.count != `WTK_COUNT_ZERO && !i_system_reset
		|=> s_q.count == $past(s_q.count) - 16'h1) else $error("count step not by one");
	AST_EC_RESET_ONLY_EXPIRY: assert property (!expire
		|=> !o_ec_reset)
		else $error("controller reset without expiry");
	AST_IND_ONLY_EXPIRY: assert property (!o_watchdog_indication && !expire
		|=> !o_watchdog_indication)
		else $error("indication without expiry");
	AST_IND_CLEAR: assert property (i_system_reset
		|=> !o_watchdog_indication)
		else $error("indication kept through system reset");
	AST_IRQ_LEVEL: assert property (o_expiry_interrupt
		== (s_q.expiry_event_flag && s_q.int_enable))
		else $error("interrupt does not follow flag and enable");

endmodule // wtk_top
